// ===== include/timer8_pkg.sv
// Overview of operation
// - counter is an eight-bit register counting up or down by direction.
// - each count strobe moves the counter by exactly one step.
// - clear forces every counter bit to zero.
// - top shows counter at top (maximum, or compare a in ctc and compare-top modes), bottom shows counter at zero.
// - each tick clears, increments or decrements the counter per mode.
// - tick source picked by clock source select; value zero stops timer.
// - software reads and writes the counter at any time.
// - software write to the counter beats clear or count that cycle.
// - counting sequence set by three mode bits across control a and b.
// - overflow flag set at mode-defined point and can request interrupt.
// - comparator checks counter against both compare values continuously.
// - compare flag sets at the edge that ends the tick on which the counter matches.
// - enabled compare interrupt is requested while its flag is set.
// - servicing the interrupt clears the matching compare flag.
// - writing one to a flag bit clears it, zero leaves it.
// - each channel match is forwarded to its own match output.
package timer8_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  // ==========================================================
  // field positions
  localparam int POS_WAVE_LO = 0;  // control a: wave mode bits 1:0
  localparam int POS_CSS = 0;      // control b: clock source 2:0
  localparam int POS_WAVE_HI = 3;  // control b: wave mode bit 2
  localparam int POS_OVF = 0;      // flags / enables
  localparam int POS_CMPA = 1;
  localparam int POS_CMPB = 2;
  // ==========================================================
  // wave mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_MAX = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_CMP = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  // ==========================================================
  // clock source codes and prescale masks (divide minus one)
  localparam logic [2:0] CSS_STOP = 3'h0;
  localparam logic [2:0] CSS_EXT_RISE = 3'h6;
  localparam logic [2:0] CSS_EXT_FALL = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_MASK_1 = 10'h000;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : timer8_pkg

// ===== design/tick_source.sv
`timescale 1ns/1ps
// ==========================================================
// tick source: prescaled pclk or edge of the external input
module tick_source (
  input wire logic pclk,                              // bus clock
  input wire logic presetn,                           // async reset, low
  input wire logic [2:0] clock_source_select,         // source code
  input wire logic ext_tick_in,                       // external source
  output logic tick                                   // one-cycle tick
);
  import timer8_pkg::*;

  logic [PRE_W-1:0] pre_ff;
  logic ext_prev_ff;
  logic tick_ff;
  logic [PRE_W-1:0] mask;
  logic rise;
  logic fall;
  logic nxt_tick;

  // ==========================================================
  // prescaler runs freely; a shared counter keeps all taps aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= '0;
      ext_prev_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
      ext_prev_ff <= ext_tick_in;
      tick_ff <= nxt_tick;
    end
  end

  // tap selection for internal sources
  assign mask = (clock_source_select == 3'h1) ? PRE_MASK_1 :
                (clock_source_select == 3'h2) ? PRE_MASK_8 :
                (clock_source_select == 3'h3) ? PRE_MASK_64 :
                (clock_source_select == 3'h4) ? PRE_MASK_256 : PRE_MASK_1024;
  assign rise = ext_tick_in & ~ext_prev_ff;
  assign fall = ~ext_tick_in & ext_prev_ff;
  assign nxt_tick = (clock_source_select == CSS_STOP) ? 1'b0 :
                    (clock_source_select == CSS_EXT_RISE) ? rise :
                    (clock_source_select == CSS_EXT_FALL) ? fall :
                    ((pre_ff & mask) == mask);
  assign tick = tick_ff;
endmodule : tick_source

// ===== design/timer8_counter_compare.sv
`timescale 1ns/1ps
// ==========================================================
// eight-bit timer/counter with two compare channels, apb slave
module timer8_counter_compare #(
  parameter int CNT_W = 8  // counter and compare width
) (
  input wire logic pclk,                       // apb clock
  input wire logic presetn,                    // async reset, low
  input wire logic psel,                       // apb select
  input wire logic penable,                    // apb enable
  input wire logic pwrite,                     // apb direction
  input wire logic [7:0] paddr,                // apb byte address
  input wire logic [31:0] pwdata,              // apb write data
  output logic [31:0] prdata,                  // apb read data
  output logic pready,                         // apb ready
  output logic pslverr,                        // apb error, unmapped
  input wire logic ext_tick_in,                // external tick source
  input wire logic irq_ack_overflow,           // overflow irq serviced
  input wire logic irq_ack_compare_a,          // compare a irq serviced
  input wire logic irq_ack_compare_b,          // compare b irq serviced
  output logic irq_overflow,                   // overflow irq request
  output logic irq_compare_a,                  // compare a irq request
  output logic irq_compare_b,                  // compare b irq request
  output logic match_a,                        // channel a match
  output logic match_b,                        // channel b match
  output logic counter_top,                    // counter at top
  output logic counter_bottom,                 // counter at zero
  output logic count_down                      // current direction
);
  import timer8_pkg::*;

  // ==========================================================
  // elaboration check
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must be 2..32");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // flag update: hardware set wins over any clear
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr);
    flag_next = (cur & ~clr) | set;
  endfunction : flag_next

  // dual-slope modes turn around at top instead of wrapping
  function automatic logic is_dual(input logic [2:0] m);
    is_dual = (m == MODE_PC_MAX) || (m == MODE_PC_CMP);
  endfunction : is_dual

  // ==========================================================
  // state
  logic [1:0] wave_lo_ff;
  logic wave_hi_ff;
  logic [2:0] css_ff;
  logic [CNT_W-1:0] counter_value_ff;
  logic [CNT_W-1:0] compare_value_a_ff;
  logic [CNT_W-1:0] compare_value_b_ff;
  logic overflow_flag_ff;
  logic compare_flag_a_ff;
  logic compare_flag_b_ff;
  logic [2:0] irq_en_ff;
  logic down_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ovf_ff;
  logic irq_a_ff;
  logic irq_b_ff;
  logic match_a_ff;
  logic match_b_ff;
  logic top_ff;
  logic bottom_ff;

  // ==========================================================
  // tick generation
  logic timer_tick;

  tick_source u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clock_source_select(css_ff),
    .ext_tick_in(ext_tick_in),
    .tick(timer_tick)
  );

  // ==========================================================
  // apb decode
  logic setup;
  logic access;
  logic wr_en;
  logic hit_ctrl_a;
  logic hit_ctrl_b;
  logic hit_count;
  logic hit_cmp_a;
  logic hit_cmp_b;
  logic hit_flags;
  logic hit_irq_en;
  logic mapped;

  // access completes only while the registered ready is up
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign wr_en = access & pwrite;
  assign hit_ctrl_a = (paddr == OFS_CTRL_A);
  assign hit_ctrl_b = (paddr == OFS_CTRL_B);
  assign hit_count = (paddr == OFS_COUNT);
  assign hit_cmp_a = (paddr == OFS_CMP_A);
  assign hit_cmp_b = (paddr == OFS_CMP_B);
  assign hit_flags = (paddr == OFS_FLAGS);
  assign hit_irq_en = (paddr == OFS_IRQ_EN);
  assign mapped = hit_ctrl_a | hit_ctrl_b | hit_count | hit_cmp_a |
                  hit_cmp_b | hit_flags | hit_irq_en;

  // ==========================================================
  // mode and top selection
  logic [2:0] wave_mode_field;
  logic [CNT_W-1:0] top_val;
  logic dual;
  logic at_top;
  logic at_bottom;

  assign wave_mode_field = {wave_hi_ff, wave_lo_ff};
  assign dual = is_dual(wave_mode_field);
  // compare a sets top in ctc and the compare-top modes
  assign top_val = (wave_mode_field == MODE_CTC ||
                    wave_mode_field == MODE_PC_CMP ||
                    wave_mode_field == MODE_FAST_CMP) ?
                   compare_value_a_ff : CNT_MAX;
  assign at_top = (counter_value_ff == top_val);
  assign at_bottom = (counter_value_ff == CNT_ZERO);

  // ==========================================================
  // counter control: clear, count and direction
  logic ctl_clear;
  logic ctl_count;
  logic nxt_down;
  logic [CNT_W-1:0] counted;
  logic [CNT_W-1:0] nxt_count;
  logic cpu_cnt_wr;

  assign ctl_clear = timer_tick & ~dual & at_top;
  assign ctl_count = timer_tick & ~ctl_clear;
  // dual slope reverses on top and on bottom
  assign nxt_down = !dual ? 1'b0 :
                    (timer_tick & at_top & ~at_bottom) ? 1'b1 :
                    (timer_tick & at_bottom) ? 1'b0 : down_ff;
  assign counted = nxt_down ? counter_value_ff - 1'b1 :
                   counter_value_ff + 1'b1;
  assign cpu_cnt_wr = wr_en & hit_count;
  assign nxt_count = cpu_cnt_wr ? pwdata[CNT_W-1:0] :
                     ctl_clear ? CNT_ZERO :
                     ctl_count ? counted : counter_value_ff;

  // ==========================================================
  // overflow event per mode
  logic ovf_evt;

  assign ovf_evt = timer_tick & (
    (dual & at_bottom) |
    ((wave_mode_field == MODE_FAST_MAX || wave_mode_field == MODE_FAST_CMP)
      & at_top) |
    (~dual & ~(wave_mode_field == MODE_FAST_MAX ||
              wave_mode_field == MODE_FAST_CMP) &
      (counter_value_ff == CNT_MAX)));

  // ==========================================================
  // comparators
  logic eq_a;
  logic eq_b;
  logic set_a;
  logic set_b;

  assign eq_a = (counter_value_ff == compare_value_a_ff);
  assign eq_b = (counter_value_ff == compare_value_b_ff);
  assign set_a = timer_tick & eq_a;
  assign set_b = timer_tick & eq_b;

  // ==========================================================
  // flag clears from software and from interrupt service
  logic clr_ovf;
  logic clr_a;
  logic clr_b;
  logic nxt_ovf;
  logic nxt_a;
  logic nxt_b;

  assign clr_ovf = (wr_en & hit_flags & pwdata[POS_OVF]) | irq_ack_overflow;
  assign clr_a = (wr_en & hit_flags & pwdata[POS_CMPA]) | irq_ack_compare_a;
  assign clr_b = (wr_en & hit_flags & pwdata[POS_CMPB]) | irq_ack_compare_b;
  assign nxt_ovf = flag_next(overflow_flag_ff, ovf_evt, clr_ovf);
  assign nxt_a = flag_next(compare_flag_a_ff, set_a, clr_a);
  assign nxt_b = flag_next(compare_flag_b_ff, set_b, clr_b);

  // ==========================================================
  // read mux
  logic [31:0] rd_mux;

  assign rd_mux = hit_ctrl_a ? 32'(wave_lo_ff) << POS_WAVE_LO :
                  hit_ctrl_b ? (32'(css_ff) << POS_CSS) |
                               (32'(wave_hi_ff) << POS_WAVE_HI) :
                  hit_count ? 32'(counter_value_ff) :
                  hit_cmp_a ? 32'(compare_value_a_ff) :
                  hit_cmp_b ? 32'(compare_value_b_ff) :
                  hit_flags ? {29'h0, compare_flag_b_ff, compare_flag_a_ff,
                               overflow_flag_ff} :
                  hit_irq_en ? {29'h0, irq_en_ff} : RST_ZERO;

  // ==========================================================
  // apb answer: ready rises one cycle after setup, no extra waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= RST_ZERO;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff <= (setup & ~pwrite) ? rd_mux : RST_ZERO;
    end
  end

  // ==========================================================
  // control registers, writable only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_lo_ff <= 2'h0;
      wave_hi_ff <= 1'b0;
      css_ff <= CSS_STOP;
      compare_value_a_ff <= '0;
      compare_value_b_ff <= '0;
      irq_en_ff <= 3'h0;
    end else if (wr_en) begin
      if (hit_ctrl_a) wave_lo_ff <= pwdata[POS_WAVE_LO +: 2];
      if (hit_ctrl_b) css_ff <= pwdata[POS_CSS +: 3];
      if (hit_ctrl_b) wave_hi_ff <= pwdata[POS_WAVE_HI];
      if (hit_cmp_a) compare_value_a_ff <= pwdata[CNT_W-1:0];
      if (hit_cmp_b) compare_value_b_ff <= pwdata[CNT_W-1:0];
      if (hit_irq_en) irq_en_ff <= pwdata[2:0];
    end
  end

  // ==========================================================
  // counter, direction and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_ff <= '0;
      down_ff <= 1'b0;
      overflow_flag_ff <= 1'b0;
      compare_flag_a_ff <= 1'b0;
      compare_flag_b_ff <= 1'b0;
    end else begin
      counter_value_ff <= nxt_count;
      down_ff <= nxt_down;
      overflow_flag_ff <= nxt_ovf;
      compare_flag_a_ff <= nxt_a;
      compare_flag_b_ff <= nxt_b;
    end
  end

  // ==========================================================
  // registered side outputs; built from next-state values, so they change with the flags they mirror
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ovf_ff <= 1'b0;
      irq_a_ff <= 1'b0;
      irq_b_ff <= 1'b0;
      match_a_ff <= 1'b0;
      match_b_ff <= 1'b0;
      top_ff <= 1'b0;
      bottom_ff <= 1'b0;
    end else begin
      irq_ovf_ff <= nxt_ovf & irq_en_ff[POS_OVF];
      irq_a_ff <= nxt_a & irq_en_ff[POS_CMPA];
      irq_b_ff <= nxt_b & irq_en_ff[POS_CMPB];
      match_a_ff <= (nxt_count == compare_value_a_ff);
      match_b_ff <= (nxt_count == compare_value_b_ff);
      top_ff <= (nxt_count == top_val);
      bottom_ff <= (nxt_count == CNT_ZERO);
    end
  end

  // ==========================================================
  // output wiring
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq_overflow = irq_ovf_ff;
  assign irq_compare_a = irq_a_ff;
  assign irq_compare_b = irq_b_ff;
  assign match_a = match_a_ff;
  assign match_b = match_b_ff;
  assign counter_top = top_ff;
  assign counter_bottom = bottom_ff;
  assign count_down = down_ff;
endmodule : timer8_counter_compare

// ===== dv/timer8_asserts.sv
`timescale 1ns/1ps
// ====================
// port-level checks: bus timing and flag stickiness
module timer8_asserts (
  input wire logic pclk,               // clock
  input wire logic presetn,            // async reset, low
  input wire logic psel,               // apb select
  input wire logic penable,            // apb enable
  input wire logic [7:0] paddr,        // apb address
  input wire logic [31:0] prdata,      // apb read data
  input wire logic pready,             // apb ready
  input wire logic pslverr,            // apb error
  input wire logic irq_ack_overflow,   // overflow serviced
  input wire logic irq_ack_compare_a,  // compare a serviced
  input wire logic irq_ack_compare_b,  // compare b serviced
  input wire logic irq_overflow,       // overflow request
  input wire logic irq_compare_a,      // compare a request
  input wire logic irq_compare_b       // compare b request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // bus cycle shape
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready_next; s_setup |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  property p_idle_zero; !pready |-> prdata == 32'h0000_0000; endproperty
  property p_unmapped; s_setup and (paddr > 8'h18) |=> pslverr; endproperty
  property p_mapped; s_setup and (paddr <= 8'h18 && paddr[1:0] == 2'h0) |=> !pslverr;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  a_err_ready: assert property (p_err_ready) else $error("error outside access");
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_mapped: assert property (p_mapped) else $error("mapped refused");
  // ====================
  // a request stays up while nothing clears its flag
  sequence s_quiet(logic ack);
    !ack && !psel;
  endsequence
  property p_ovf_sticky;
    s_quiet(irq_ack_overflow) [*2] ##0 irq_overflow |=> irq_overflow;
  endproperty
  property p_cmpa_sticky;
    s_quiet(irq_ack_compare_a) [*2] ##0 irq_compare_a |=> irq_compare_a;
  endproperty
  property p_cmpb_sticky;
    s_quiet(irq_ack_compare_b) [*2] ##0 irq_compare_b |=> irq_compare_b;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped");
  a_cmpa_sticky: assert property (p_cmpa_sticky) else $error("compare a dropped");
  a_cmpb_sticky: assert property (p_cmpb_sticky) else $error("compare b dropped");
endmodule : timer8_asserts

bind timer8_counter_compare timer8_asserts chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_ack_overflow(irq_ack_overflow), .irq_ack_compare_a(irq_ack_compare_a),
  .irq_ack_compare_b(irq_ack_compare_b), .irq_overflow(irq_overflow),
  .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b)
);

// ===== dv/tb_top.sv
`timescale 1ns/1ps
// ====================
// self-checking bench for the timer and its compare channels
module tb_top;
  import timer8_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ext_tick_in = 1'b0, irq_ack_overflow = 1'b0;
  logic irq_ack_compare_a = 1'b0, irq_ack_compare_b = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_overflow, irq_compare_a, irq_compare_b;
  logic match_a, match_b, counter_top, counter_bottom, count_down, saw_down;
  logic [5:0] obs;
  int failures = 0;
  int samples_checked = 0;
  // watched outputs, indexed by the wait task
  assign obs = {counter_top, irq_compare_b, irq_compare_a, irq_overflow, match_b, match_a};
  // 125 MHz
  always #4 pclk = ~pclk;
  timer8_counter_compare #(.CNT_W(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_tick_in(ext_tick_in), .irq_ack_overflow(irq_ack_overflow),
    .irq_ack_compare_a(irq_ack_compare_a), .irq_ack_compare_b(irq_ack_compare_b),
    .irq_overflow(irq_overflow), .irq_compare_a(irq_compare_a),
    .irq_compare_b(irq_compare_b), .match_a(match_a), .match_b(match_b),
    .counter_top(counter_top), .counter_bottom(counter_bottom), .count_down(count_down)
  );
  // ====================
  // reporting and comparison
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  // ====================
  // apb master: holds the request until ready, then one idle edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("ERROR t=%0t ready never came", $time);
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd
  // bounded wait for one watched output; also notes any down-count
  task automatic wait_sig(input int s, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (count_down === 1'b1) saw_down = 1'b1;
    end while (obs[s] !== lvl && n < 1200);
    if (n >= 1200) begin
      failures++;
      $display("ERROR t=%0t output %0d stuck", $time, s);
      report_and_stop();
    end
  endtask : wait_sig
  // one-cycle service pulse: 0 overflow, 1 compare a, 2 compare b
  task automatic ack(input int s);
    irq_ack_overflow <= (s == 0);
    irq_ack_compare_a <= (s == 1);
    irq_ack_compare_b <= (s == 2);
    @(posedge pclk);
    {irq_ack_overflow, irq_ack_compare_a, irq_ack_compare_b} <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask : ack
  // ====================
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000, r, e);
      check_word(r, 32'h0000_0000);
    end
    check_bit(counter_bottom, 1'b1);
    apb(1'b0, 8'h1C, 32'h0000_0000, r, e);
    check_bit(e, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_stopped();
    logic [31:0] r;
    wr(OFS_COUNT, 32'h0000_005A);
    repeat (20) @(posedge pclk);
    rd(OFS_COUNT, r);
    check_word(r, 32'h0000_005A);
    wr(OFS_CMP_A, 32'h0000_005A);
    wr(OFS_CMP_B, 32'h0000_005A);
    repeat (2) @(posedge pclk);
    check_bit(match_a & match_b, 1'b1);
    wr(OFS_CMP_A, 32'h0000_0010);
    wr(OFS_CMP_B, 32'h0000_0012);
    repeat (2) @(posedge pclk);
    check_bit(match_a | match_b, 1'b0);
    $display("stopped access test done");
  endtask : t_stopped
  task automatic t_count();
    logic [31:0] v1, v2;
    int n;
    wr(OFS_IRQ_EN, 32'h0000_0007);
    wr(OFS_COUNT, 32'h0000_0020);
    wr(OFS_CTRL_B, 32'h0000_0001);
    rd(OFS_COUNT, v1);
    rd(OFS_COUNT, v2);
    check_word(v2 - v1, 32'h0000_0003);
    wr(OFS_COUNT, 32'h0000_0080);
    rd(OFS_COUNT, v1);
    check_bit(v1 >= 32'h0000_0080 && v1 <= 32'h0000_0084, 1'b1);
    wr(OFS_COUNT, 32'h0000_00F0);
    wait_sig(2, 1'b1, n);
    check_bit(n < 40, 1'b1);
    wr(OFS_CTRL_B, 32'h0000_0000);
    rd(OFS_COUNT, v1);
    rd(OFS_COUNT, v2);
    check_word(v2, v1);
    wr(OFS_FLAGS, 32'h0000_0000);
    rd(OFS_FLAGS, v1);
    check_word(v1 & 32'h0000_0001, 32'h0000_0001);
    ack(0);
    check_bit(irq_overflow, 1'b0);
    wr(OFS_FLAGS, 32'h0000_0007);
    $display("count test done");
  endtask : t_count
  task automatic t_compare();
    logic [31:0] r;
    int n;
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL_B, 32'h0000_0002);
    wait_sig(0, 1'b1, n);
    check_bit(irq_compare_a, 1'b0);
    wait_sig(3, 1'b1, n);
    check_bit(n >= 4 && n <= 12, 1'b1);
    wait_sig(4, 1'b1, n);
    wr(OFS_CTRL_B, 32'h0000_0000);
    ack(1);
    check_bit(irq_compare_a, 1'b0);
    check_bit(irq_compare_b, 1'b1);
    wr(OFS_FLAGS, 32'h0000_0004);
    rd(OFS_FLAGS, r);
    check_word(r, 32'h0000_0000);
    $display("compare test done");
  endtask : t_compare
  task automatic t_modes();
    logic [2:0] tab [6] = '{MODE_CTC, MODE_FAST_CMP, MODE_PC_CMP, MODE_NORMAL,
                           MODE_FAST_MAX, MODE_PC_MAX};
    logic [2:0] m;
    logic dual;
    int top, n, p;
    wr(OFS_CMP_A, 32'h0000_0005);
    // channel b on the same value keeps its flag set for the service check
    wr(OFS_CMP_B, 32'h0000_0005);
    for (int i = 0; i < 6; i++) begin
      m = tab[i];
      dual = (m == MODE_PC_MAX || m == MODE_PC_CMP);
      top = (m == MODE_CTC || m == MODE_FAST_CMP || m == MODE_PC_CMP) ? 5 : 255;
      wr(OFS_CTRL_B, 32'h0000_0000);
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_CTRL_A, {30'h0000_0000, m[1:0]});
      wr(OFS_CTRL_B, {28'h000_0000, m[2], 3'h1});
      wait_sig(5, 1'b1, n);
      saw_down = 1'b0;
      wait_sig(5, 1'b0, n);
      wait_sig(5, 1'b1, p);
      check_word(32'(n + p), dual ? 32'(2 * top) : 32'(top + 1));
      check_bit(saw_down, dual);
    end
    wr(OFS_CTRL_B, 32'h0000_0000);
    $display("mode test done");
  endtask : t_modes
  task automatic pulses();
    repeat (3) begin
      ext_tick_in <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_tick_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : pulses
  task automatic t_ext();
    logic [31:0] r;
    wr(OFS_CTRL_A, 32'h0000_0000);
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL_B, {29'h0000_0000, CSS_EXT_RISE});
    pulses();
    rd(OFS_COUNT, r);
    check_word(r, 32'h0000_0003);
    wr(OFS_CTRL_B, {29'h0000_0000, CSS_EXT_FALL});
    pulses();
    rd(OFS_COUNT, r);
    check_word(r, 32'h0000_0006);
    check_bit(irq_compare_b, 1'b1);
    ack(2);
    check_bit(irq_compare_b, 1'b0);
    // prescaled taps: free-running phase allows four or five ticks in the window
    for (int k = 0; k < 3; k++) begin
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_CTRL_B, 32'(3 + k));
      repeat (256 << (2 * k)) @(posedge pclk);
      wr(OFS_CTRL_B, 32'h0000_0000);
      rd(OFS_COUNT, r);
      check_bit(r >= 32'h0000_0004 && r <= 32'h0000_0005, 1'b1);
    end
    $display("external source test done");
  endtask : t_ext
  // ====================
  // main sequence: reset held ten cycles
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_stopped();
    t_count();
    t_compare();
    t_modes();
    t_ext();
    report_and_stop();
  end
endmodule : tb_top
